//--- rtl/ueie_pkg.sv
package ueie_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] UEIE_ERR_EN_OFFSET = 8'h00;
  localparam logic [7:0] UEIE_IRQ_EN_OFFSET = 8'h04;
  localparam logic [7:0] UEIE_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] UEIE_MASK_OFFSET = 8'h0c;
  localparam logic [7:0] UEIE_FLAGS_OFFSET = 8'h10;
  localparam logic [7:0] UEIE_ERR_EN_RESET = 8'h00;
  localparam logic [1:0] UEIE_IRQ_EN_RESET = 2'h0;
  localparam logic [1:0] UEIE_MASK_RESET = 2'h0;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int UEIE_BIT_PID = 0;
  localparam int UEIE_BIT_CRC5_EOF = 1;
  localparam int UEIE_BIT_CRC16 = 2;
  localparam int UEIE_BIT_FIELD = 3;
  localparam int UEIE_BIT_TURN = 4;
  localparam int UEIE_BIT_DMA = 5;
  localparam int UEIE_BIT_BMX = 6;
  localparam int UEIE_BIT_STUFF = 7;
  localparam int UEIE_BIT_ERR_SUMMARY = 1;
  localparam int UEIE_EVT_ERR = 0;
  localparam int UEIE_EVT_MODULE = 1;

  localparam logic [1:0] UEIE_RESP_OKAY = 2'h0;
  localparam logic [1:0] UEIE_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    UEIE_W_IDLE = 3'b001,
    UEIE_W_RESP = 3'b010,
    UEIE_W_HOLD = 3'b100
  } ueie_wstate_e;
endpackage

//--- rtl/ueie_gate_if.sv
`timescale 1ns/1ps
// error flags, enables and role between the top and the gating core
interface ueie_gate_if;
  logic [7:0] flags;
  logic [7:0] enables;
  logic host_role;
  logic err_req;
  modport core (input flags, input enables, input host_role,
    output err_req);
  modport top (output flags, output enables, output host_role,
    input err_req);
endinterface

//--- rtl/ueie_gate.sv
`timescale 1ns/1ps
module ueie_gate (
  ueie_gate_if.core gate
);
  import ueie_pkg::*;

  // ************************************************************
  // error gating
  // ************************************************************
  // bit 1 flag is already selected by role in the top
  always_comb begin
    gate.err_req = |(gate.flags & gate.enables);
  end
endmodule

//--- rtl/ueie_top.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module ueie_top (
  input wire logic i_clock,
  input wire logic i_reset_n,
  // error flags from the same clock domain
  input wire logic i_bitstuff_err_flag,
  input wire logic i_busmatrix_err_flag,
  input wire logic i_dma_err_flag,
  input wire logic i_turnaround_timeout_flag,
  input wire logic i_field_size_err_flag,
  input wire logic i_crc_sixteen_fail_flag,
  input wire logic i_crc_five_err_flag,
  input wire logic i_end_of_frame_err_flag,
  input wire logic i_packet_id_fail_flag,
  input wire logic i_host_role,
  // AXI4-Lite slave
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // outputs
  output logic o_err_irq_req,
  output logic o_usb_module_irq_flag,
  output logic o_irq
);
  import ueie_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] err_en;
    logic [1:0] irq_en;
    logic [1:0] status;
    logic [1:0] mask;
    logic err_req;
    logic mod_flag;
    logic err_req_prev;
    logic mod_flag_prev;
    logic [7:0] awaddr;
    logic aw_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_have;
    ueie_wstate_e wstate;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ueie_state_s;

  ueie_state_s s_q;
  ueie_state_s s_d;
  ueie_gate_if gate ();
  logic [7:0] flags;
  logic [1:0] events;
  // merged byte 0 for the two bit registers, cut to width below
  logic [7:0] irq_en_merged;
  logic [7:0] mask_merged;

  // byte lane merge for an eight bit field
  function automatic logic [7:0] ueie_merge8(input logic [7:0] old_v,
      input logic [31:0] data, input logic [3:0] strb);
    ueie_merge8 = strb[0] ? data[7:0] : old_v;
  endfunction

  // ************************************************************
  // flag assembly and gating
  // ************************************************************
  always_comb begin
    flags = '0;
    flags[UEIE_BIT_STUFF] = i_bitstuff_err_flag;
    flags[UEIE_BIT_BMX] = i_busmatrix_err_flag;
    flags[UEIE_BIT_DMA] = i_dma_err_flag;
    flags[UEIE_BIT_TURN] = i_turnaround_timeout_flag;
    flags[UEIE_BIT_FIELD] = i_field_size_err_flag;
    flags[UEIE_BIT_CRC16] = i_crc_sixteen_fail_flag;
    // one enable bit, two meanings picked by role
    flags[UEIE_BIT_CRC5_EOF] = i_host_role ?
      i_end_of_frame_err_flag :
      i_crc_five_err_flag;
    flags[UEIE_BIT_PID] = i_packet_id_fail_flag;
  end

  assign gate.flags = flags;
  assign gate.enables = s_q.err_en;
  assign gate.host_role = i_host_role;

  ueie_gate u_gate (
    .gate(gate.core)
  );

  // ************************************************************
  // handshake and interrupt outputs
  // ************************************************************
  assign o_s_axi_awready = !s_q.aw_have && s_q.wstate == UEIE_W_IDLE;
  assign o_s_axi_wready = !s_q.w_have && s_q.wstate == UEIE_W_IDLE;
  assign o_s_axi_bvalid = s_q.wstate == UEIE_W_RESP;
  assign o_s_axi_bresp = s_q.bresp;
  assign o_s_axi_arready = !s_q.rvalid;
  assign o_s_axi_rvalid = s_q.rvalid;
  assign o_s_axi_rdata = s_q.rdata;
  assign o_s_axi_rresp = s_q.rresp;
  assign o_err_irq_req = s_q.err_req;
  assign o_usb_module_irq_flag = s_q.mod_flag;
  assign o_irq = |(s_q.status & s_q.mask);
  assign irq_en_merged = ueie_merge8({6'h00, s_q.irq_en}, s_q.wdata,
    s_q.wstrb);
  assign mask_merged = ueie_merge8({6'h00, s_q.mask}, s_q.wdata,
    s_q.wstrb);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    // registered so the outputs are glitch free
    s_d.err_req = gate.err_req;
    s_d.mod_flag = gate.err_req &&
      s_q.irq_en[UEIE_BIT_ERR_SUMMARY];
    s_d.err_req_prev = s_q.err_req;
    s_d.mod_flag_prev = s_q.mod_flag;
    events = '0;
    events[UEIE_EVT_ERR] = s_q.err_req && !s_q.err_req_prev;
    events[UEIE_EVT_MODULE] = s_q.mod_flag && !s_q.mod_flag_prev;

    // capture address and data in either order
    if (o_s_axi_awready && i_s_axi_awvalid) begin
      s_d.awaddr = i_s_axi_awaddr;
      s_d.aw_have = 1'b1;
    end
    if (o_s_axi_wready && i_s_axi_wvalid) begin
      s_d.wdata = i_s_axi_wdata;
      s_d.wstrb = i_s_axi_wstrb;
      s_d.w_have = 1'b1;
    end

    case (s_q.wstate)
      UEIE_W_IDLE: begin
        if (s_q.aw_have && s_q.w_have) begin
          s_d.wstate = UEIE_W_HOLD;
        end
      end
      UEIE_W_HOLD: begin
        s_d.bresp = UEIE_RESP_OKAY;
        s_d.aw_have = 1'b0;
        s_d.w_have = 1'b0;
        s_d.wstate = UEIE_W_RESP;
        case (s_q.awaddr)
          UEIE_ERR_EN_OFFSET: begin
            // upper lanes have no storage
            s_d.err_en = ueie_merge8(s_q.err_en, s_q.wdata,
              s_q.wstrb);
          end
          UEIE_IRQ_EN_OFFSET: begin
            s_d.irq_en = irq_en_merged[1:0];
          end
          UEIE_STATUS_OFFSET: begin
            if (s_q.wstrb[0]) begin
              s_d.status = s_q.status & ~s_q.wdata[1:0];
            end
          end
          UEIE_MASK_OFFSET: begin
            s_d.mask = mask_merged[1:0];
          end
          UEIE_FLAGS_OFFSET: begin
          end
          default: begin
            s_d.bresp = UEIE_RESP_SLVERR;
          end
        endcase
      end
      UEIE_W_RESP: begin
        if (i_s_axi_bready) begin
          s_d.wstate = UEIE_W_IDLE;
        end
      end
      default: begin
        s_d.wstate = UEIE_W_IDLE;
      end
    endcase

    // set wins over a same-cycle write-one clear
    s_d.status = s_d.status | events;

    // read channel
    if (s_q.rvalid) begin
      if (i_s_axi_rready) begin
        s_d.rvalid = 1'b0;
      end
    end else if (i_s_axi_arvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = UEIE_RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      case (i_s_axi_araddr)
        UEIE_ERR_EN_OFFSET: s_d.rdata = {24'h00_0000, s_q.err_en};
        UEIE_IRQ_EN_OFFSET: s_d.rdata = {30'h0, s_q.irq_en};
        UEIE_STATUS_OFFSET: s_d.rdata = {30'h0, s_q.status};
        UEIE_MASK_OFFSET: s_d.rdata = {30'h0, s_q.mask};
        UEIE_FLAGS_OFFSET: s_d.rdata = {24'h00_0000, flags};
        default: s_d.rresp = UEIE_RESP_SLVERR;
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_q <= '0;
      s_q.err_en <= UEIE_ERR_EN_RESET;
      s_q.irq_en <= UEIE_IRQ_EN_RESET;
      s_q.mask <= UEIE_MASK_RESET;
      s_q.wstate <= UEIE_W_IDLE;
      s_q.bresp <= UEIE_RESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

//--- dv/ueie_properties.sv
`timescale 1ns/1ps
// ******************
// bus and flag checks
// ******************
module ueie_properties (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic [1:0] o_s_axi_bresp,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic [1:0] o_s_axi_rresp,
  input wire logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  input wire logic o_err_irq_req,
  input wire logic o_usb_module_irq_flag
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // address and data taken at one edge
  sequence s_wr_taken;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_rd_taken;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##[1:4] o_s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_taken |=> o_s_axi_rvalid)
    else $error("read response late");
  a_bresp_holds: assert property (o_s_axi_bvalid && !i_s_axi_bready
    |=> o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("bresp lost");
  a_rdata_holds: assert property (o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("rdata lost");
  a_bresp_drops: assert property (o_s_axi_bvalid && i_s_axi_bready
    |=> !o_s_axi_bvalid) else $error("bvalid stuck");
  a_arready_free: assert property (o_s_axi_arready == !o_s_axi_rvalid)
    else $error("arready wrong");
  a_busy_refuses: assert property (o_s_axi_bvalid
    |-> !o_s_axi_awready && !o_s_axi_wready) else $error("write overlap");
  // module flag only follows a standing error request
  a_module_gated: assert property (o_usb_module_irq_flag
    |-> o_err_irq_req || $past(o_err_irq_req)) else $error("module flag");
endmodule
bind ueie_top ueie_properties i_ueie_properties (.*);

//--- dv/ueie_flag_src.sv
`timescale 1ns/1ps
// ******************
// error flag source
// ******************
module ueie_flag_src (
  input wire logic i_clock,
  input wire logic [8:0] i_pattern,
  output logic [8:0] o_flags
);
  // levels launched on the clock, as the detectors would
  always_ff @(posedge i_clock) begin
    o_flags <= i_pattern;
  end
endmodule

//--- dv/ueie_top_tb.sv
`timescale 1ns/1ps
// ******************
// bench
// ******************
module ueie_top_tb;
  import ueie_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, role = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [8:0] pat = 9'h000;
  logic [8:0] fl;
  logic [7:0] aa = 8'h00, ra = 8'h00;
  logic [31:0] wd = 32'h0, rd, d, seed = 32'h000119db;
  logic awr, wr, bv, arr, rv, req, mod, irq;
  logic [1:0] br, rr, r;
  int err_total = 0, comparisons = 0;
  initial forever #20 clock = ~clock;
  ueie_flag_src i_ueie_flag_src (.i_clock(clock), .i_pattern(pat),
    .o_flags(fl));
  ueie_top i_ueie_top (.i_clock(clock), .i_reset_n(rst_n),
    .i_bitstuff_err_flag(fl[7]), .i_busmatrix_err_flag(fl[6]),
    .i_dma_err_flag(fl[5]), .i_turnaround_timeout_flag(fl[4]),
    .i_field_size_err_flag(fl[3]), .i_crc_sixteen_fail_flag(fl[2]),
    .i_crc_five_err_flag(fl[1]), .i_end_of_frame_err_flag(fl[8]),
    .i_packet_id_fail_flag(fl[0]), .i_host_role(role),
    .i_s_axi_awaddr(aa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr), .o_s_axi_bresp(br), .o_s_axi_bvalid(bv),
    .i_s_axi_bready(bry), .i_s_axi_araddr(ra), .i_s_axi_arvalid(arv),
    .o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rry), .o_err_irq_req(req),
    .o_usb_module_irq_flag(mod), .o_irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // bit 1 follows the role: end-of-frame in host, crc5 in device
  function automatic logic exp_req(input logic [7:0] en,
    input logic [8:0] f, input logic h);
    return |(en & {f[7:2], h ? f[8] : f[1], f[0]});
  endfunction
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // bounded waits: a hang ends the run as a mismatch
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] o);
    int n;
    n = 0;
    @(posedge clock);
    aa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv && n < 50);
    o = br;
    bry <= 1'b0;
    if (n >= 50) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] o);
    int n;
    n = 0;
    @(posedge clock);
    ra <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 50);
    v = rd;
    o = rr;
    rry <= 1'b0;
    if (n >= 50) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  // program enables, raise flags, then compare both requests
  task automatic try(input logic [7:0] en, input logic [8:0] f,
    input logic h, input logic s);
    logic [1:0] o;
    logic [31:0] v;
    wr_reg(UEIE_ERR_EN_OFFSET, {seed[31:8], en}, o);
    rd_reg(UEIE_ERR_EN_OFFSET, v, o);
    chk("err_en", {24'h0, en}, v);
    wr_reg(UEIE_IRQ_EN_OFFSET, {30'h0, s, 1'b0}, o);
    pat <= f;
    role <= h;
    repeat (4) @(posedge clock);
    chk("err_req", 32'(exp_req(en, f, h)), 32'(req));
    chk("module_flag", 32'(exp_req(en, f, h) & s), 32'(mod));
  endtask
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    rd_reg(UEIE_ERR_EN_OFFSET, d, r);
    chk("en_reset", 32'h0, d);
    for (int j = 0; j < 9; j++) begin
      try(8'hff, 9'h1 << j, 1'b0, 1'b1);
      try(8'hff, 9'h1 << j, 1'b1, 1'b0);
      try(~(8'h1 << (j % 8)), 9'h1 << j, j[0], 1'b1);
    end
    for (int i = 0; i < 30; i++) begin
      seed = lfsr(seed);
      try(seed[7:0], seed[20:12], seed[21], seed[9]);
    end
    // unmapped place answers with an error and no data
    rd_reg(8'h20, d, r);
    chk("rresp", 32'(UEIE_RESP_SLVERR), 32'(r));
    chk("rdata", 32'h0, d);
    wr_reg(8'h20, 32'hffffffff, r);
    chk("bresp", 32'(UEIE_RESP_SLVERR), 32'(r));
    // event sets status, mask gates the line, one-to-clear
    try(8'h01, 9'h000, 1'b0, 1'b1);
    wr_reg(UEIE_MASK_OFFSET, 32'h0, r);
    wr_reg(UEIE_STATUS_OFFSET, 32'h3, r);
    try(8'h01, 9'h001, 1'b0, 1'b1);
    rd_reg(UEIE_STATUS_OFFSET, d, r);
    chk("status", 32'h3, d);
    chk("irq_masked", 32'h0, 32'(irq));
    wr_reg(UEIE_MASK_OFFSET, 32'h3, r);
    @(posedge clock);
    chk("irq_on", 32'h1, 32'(irq));
    wr_reg(UEIE_STATUS_OFFSET, 32'h3, r);
    @(posedge clock);
    chk("irq_cleared", 32'h0, 32'(irq));
    tally_and_finish;
  end
endmodule
